// *** snl_bit_timer.sv ***
// Bit period timer that marks mid-bit and end-of-bit moments.
`timescale 1ns/100ps
`default_nettype none

module snl_bit_timer
  import snl_pkg::*;
#(
  parameter int unsigned PERIOD = BIT_CYCLES
)
(
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic run,
  output logic      mid_tick,
  output logic      end_tick
);

  localparam int unsigned W = $clog2(PERIOD);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  localparam logic [W-1:0] MID = W'(PERIOD / 2 - 1);

  logic [W-1:0] count;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      count <= '0;
    else if (!run || count == LAST)
      count <= '0;
    else
      count <= count + W'(1);
  end

  assign mid_tick = run && count == MID;
  assign end_tick = run && count == LAST;

endmodule

`default_nettype wire

// *** snl_host.sv ***
// Host model on the pulled-up serial wire.
`timescale 1ns/100ps
`default_nettype none

module snl_host
#(
  parameter int unsigned P = 16
)
(
  input  wire logic CLK,
  input  wire logic LINE_OE,
  output logic      line
);
  logic host_low = 1'b0;

  assign line = ~(LINE_OE | host_low);

  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge CLK) host_low <= ~f[i];
      repeat (P - 1) @(posedge CLK);
    end
    @(posedge CLK) host_low <= 1'b0;
  endtask

  // Samples mid-bit, so a skew of under half a bit still passes.
  task automatic get(output logic [7:0] b, output logic stop);
    int n;
    n = 0;
    while (line && n < 4000)
    begin
      @(posedge CLK);
      n++;
    end
    repeat (P / 2) @(posedge CLK);
    for (int i = 0; i < 8; i++)
    begin
      repeat (P) @(posedge CLK);
      b[i] = line;
    end
    repeat (P) @(posedge CLK);
    stop = line;
  endtask
endmodule

`default_nettype wire

// *** snl_link.sv ***
// Single pin serial byte link with register port and interrupt.
//
// Functional notes
// RULE_01 - Every bit on the line lasts 256 clock cycles.
// RULE_02 - Reception uses the same NRZ framing and bit rate as the monitor link.
// RULE_03 - A requested receive waits for a low start bit, then takes a whole character.
// RULE_04 - A line that is not high at the stop bit position is a framing error.
// RULE_05 - The stop flag is set on a good stop bit and cleared on a framing error.
// RULE_06 - The assembled byte is handed to software when the character completes.
// RULE_07 - The board pulls the line up so it idles high when nobody drives it low.
// RULE_08 - The pin rests as an input with a zero output latch, and data is loaded before a send.
// RULE_09 - Transmission uses the same framing and bit rate as reception.
// RULE_10 - Neither path services the watchdog or blocks interrupts during a character.
// RULE_11 - Software should hold off its own interrupts while a character is received.
// RULE_12 - A character is one low start bit, eight data bits LSB first and one high stop bit.
// RULE_13 - A low bit turns the pin to output with the zero latch; a high bit releases it.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module snl_link
  import snl_pkg::*;
#(
  parameter int unsigned BIT_PERIOD = BIT_CYCLES
)
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       LINE_IN,
  output logic            LINE_OUT,
  output logic            LINE_OE,
  output logic            IRQ
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} snl_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} snl_tx_e;

  snl_bus_s bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic line_meta;
  logic line_sync;
  snl_rx_e rx_state;
  snl_tx_e tx_state;
  logic [2:0] rx_bit;
  logic [2:0] tx_bit;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] tx_data;
  snl_rx_result_s rx_result;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] irq_event;
  logic rx_mid;
  logic rx_end;
  logic tx_mid;
  logic tx_end;
  logic rx_run;
  logic tx_run;
  logic rx_go;
  logic tx_go;
  logic rx_cancel;
  logic rx_done;
  logic tx_done;
  logic tx_low;
  logic rx_armed;

  assign rx_go = bus.wr && bus.addr == ADDR_CTRL && bus.wdata[CTRL_RX_GO];
  assign tx_go = bus.wr && bus.addr == ADDR_CTRL && bus.wdata[CTRL_TX_GO];
  assign rx_cancel = bus.wr && bus.addr == ADDR_CTRL && bus.wdata[CTRL_RX_CANCEL];

  // RULE_02 NRZ line sampling.
  // The line comes from the pin, so it is resynchronised before use.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end
    else
    begin
      line_meta <= LINE_IN;
      line_sync <= line_meta;
    end
  end

  // RULE_01 bit timing.
  snl_bit_timer #(.PERIOD(BIT_PERIOD)) u_rx_timer
  (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .run      (rx_run),
    .mid_tick (rx_mid),
    .end_tick (rx_end)
  );

  // RULE_09 same rate out.
  snl_bit_timer #(.PERIOD(BIT_PERIOD)) u_tx_timer
  (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .run      (tx_run),
    .mid_tick (tx_mid),
    .end_tick (tx_end)
  );

  // The receive timer starts on the start edge, so the sample at mid-bit sits centred.
  assign rx_run = rx_state != RX_IDLE;
  assign tx_run = tx_state != TX_IDLE;

  // RULE_03 wait for start.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rx_state <= RX_IDLE;
    else if (rx_cancel)
      rx_state <= RX_IDLE;
    else
    begin
      unique case (rx_state)
        RX_IDLE:
          if (rx_go || rx_armed)
            rx_state <= line_sync ? RX_IDLE : RX_START;
        RX_START:
          if (rx_mid && line_sync)
            rx_state <= RX_IDLE;
          else if (rx_end)
            rx_state <= RX_DATA;
        RX_DATA:
          if (rx_end && rx_bit == 3'h7)
            rx_state <= RX_STOP;
        RX_STOP:
          if (rx_mid)
            rx_state <= RX_IDLE;
      endcase
    end
  end

  // A receive request stays armed until a character finishes or is cancelled.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rx_armed <= 1'b0;
    else if (rx_cancel || rx_done)
      rx_armed <= 1'b0;
    else if (rx_go)
      rx_armed <= 1'b1;
  end

  // RULE_12 data LSB first.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_bit <= 3'h0;
      rx_shift <= RESET_BYTE;
    end
    else if (rx_state == RX_DATA && rx_mid)
      rx_shift <= {line_sync, rx_shift[7:1]};
    else if (rx_state == RX_DATA && rx_end)
      rx_bit <= rx_bit + 3'h1;
    else if (rx_state != RX_DATA)
      rx_bit <= 3'h0;
  end

  assign rx_done = rx_state == RX_STOP && rx_mid;

  // RULE_04 stop check.
  // RULE_05 stop flag.
  // RULE_06 deliver byte.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rx_result <= '{data: RESET_BYTE, stop_ok: 1'b0};
    else if (rx_done)
      rx_result <= '{data: rx_shift, stop_ok: line_sync};
  end

  // RULE_08 data loaded first.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      tx_data <= RESET_BYTE;
    else if (bus.wr && bus.addr == ADDR_TX_DATA)
      tx_data <= bus.wdata;
  end

  // RULE_12 framing out.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tx_state <= TX_IDLE;
      tx_bit <= 3'h0;
      tx_shift <= RESET_BYTE;
    end
    else
    begin
      unique case (tx_state)
        TX_IDLE:
          if (tx_go)
          begin
            tx_state <= TX_START;
            tx_shift <= tx_data;
            tx_bit <= 3'h0;
          end
        TX_START:
          if (tx_end)
            tx_state <= TX_DATA;
        TX_DATA:
          if (tx_end)
          begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h7)
              tx_state <= TX_STOP;
          end
        TX_STOP:
          if (tx_end)
            tx_state <= TX_IDLE;
      endcase
    end
  end

  assign tx_done = tx_state == TX_STOP && tx_end;
  assign tx_low = tx_state == TX_START || (tx_state == TX_DATA && !tx_shift[0]);

  // RULE_08 zero latch rest.
  // RULE_13 open drain drive.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      LINE_OE <= 1'b0;
    else
      LINE_OE <= tx_low;
  end

  // The output latch is held at zero so enabling the driver can only pull low.
  assign LINE_OUT = 1'b0;

  // RULE_10 no interrupt gating.
  assign irq_event = {tx_done, rx_done && !line_sync, rx_done};

  // Set wins over write-one-to-clear so no event is lost.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      irq_stat <= RESET_IRQ;
    else if (bus.wr && bus.addr == ADDR_IRQ_STAT)
      irq_stat <= (irq_stat & ~bus.wdata[IRQ_BITS-1:0]) | irq_event;
    else
      irq_stat <= irq_stat | irq_event;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      irq_mask <= RESET_IRQ;
    else if (bus.wr && bus.addr == ADDR_IRQ_MASK)
      irq_mask <= bus.wdata[IRQ_BITS-1:0];
  end

  assign IRQ = |(irq_stat & irq_mask);

  // Unmapped addresses read as zero.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        ADDR_CTRL:
          RDATA <= {7'h00, rx_armed};
        ADDR_STATUS:
          RDATA <= {4'h0, line_sync, rx_result.stop_ok, tx_run, rx_run || rx_armed};
        ADDR_TX_DATA:
          RDATA <= tx_data;
        ADDR_RX_DATA:
          RDATA <= rx_result.data;
        ADDR_IRQ_STAT:
          RDATA <= {5'h00, irq_stat};
        ADDR_IRQ_MASK:
          RDATA <= {5'h00, irq_mask};
        default:
          RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end

endmodule

`default_nettype wire

// *** snl_link_props.sv ***
// Concurrent checks on the ports of the serial byte link.
`timescale 1ns/100ps
`default_nettype none

module snl_link_props
  import snl_pkg::*;
#(
  parameter int unsigned BIT_PERIOD = BIT_CYCLES
)
(
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       LINE_IN,
  input wire logic       LINE_OUT,
  input wire logic       LINE_OE,
  input wire logic       IRQ
);
  // Length of the current driven-low stretch, so bit widths can be judged.
  int unsigned run;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      run <= 0;
    else
      run <= LINE_OE ? run + 1 : 0;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_wr(logic [3:0] a);
    WR && ADDR == a;
  endsequence
  sequence s_wr_rd(logic [3:0] a);
    s_wr(a) ##1 (RD && ADDR == a);
  endsequence

  property p_out_zero;
    LINE_OUT == 1'b0;
  endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("line output latch is not zero");
  property p_rd_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_oe_len;
    $fell(LINE_OE) |-> (run % BIT_PERIOD) == 0;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("low stretch is not whole bits");
  property p_oe_max;
    LINE_OE |-> run < 9 * BIT_PERIOD;
  endproperty
  a_oe_max: assert property (p_oe_max)
    else $error("low stretch longer than start plus eight bits");
  property p_reset_oe;
    $rose(RST_B) |-> !LINE_OE;
  endproperty
  a_reset_oe: assert property (p_reset_oe)
    else $error("pin driven right after reset");
  property p_mask_off;
    s_wr(ADDR_IRQ_MASK) ##0 WDATA == 8'h00 |=> !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with all masked");
  property p_line_st;
    LINE_IN [*5] ##0 (RD && ADDR == ADDR_STATUS) |=> RDATA[ST_LINE];
  endproperty
  a_line_st: assert property (p_line_st)
    else $error("status shows a low line while idle high");
  property p_txd_rb;
    s_wr_rd(ADDR_TX_DATA) |=> RDATA == $past(WDATA, 2);
  endproperty
  a_txd_rb: assert property (p_txd_rb)
    else $error("send byte readback differs");
endmodule

`default_nettype wire

// *** snl_pkg.sv ***
// Package with constants and types for the single pin serial byte link.
package snl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_CYCLES = 256;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TX_DATA = 4'h2;
  localparam logic [3:0] ADDR_RX_DATA = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;

  localparam int unsigned CTRL_RX_GO = 0;
  localparam int unsigned CTRL_TX_GO = 1;
  localparam int unsigned CTRL_RX_CANCEL = 2;

  localparam int unsigned ST_RX_BUSY = 0;
  localparam int unsigned ST_TX_BUSY = 1;
  localparam int unsigned ST_STOP_OK = 2;
  localparam int unsigned ST_LINE = 3;

  localparam int unsigned IRQ_RX_DONE = 0;
  localparam int unsigned IRQ_FRAME_ERR = 1;
  localparam int unsigned IRQ_TX_DONE = 2;
  localparam int unsigned IRQ_BITS = 3;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [IRQ_BITS-1:0] RESET_IRQ = 3'h0;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } snl_bus_s;

  typedef struct packed {
    logic [7:0] data;
    logic       stop_ok;
  } snl_rx_result_s;

endpackage

// *** testbench.sv ***
// Self-checking bench for the serial byte link.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import snl_pkg::*;
  localparam int unsigned P = 16;
  logic       CLK = 1'b0;
  logic       RST_B = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic [7:0] RDATA;
  logic       LINE_IN;
  logic       LINE_OUT;
  logic       LINE_OE;
  logic       IRQ;
  int         mismatches = 0;
  int         n_compared = 0;
  logic [7:0] v;
  logic       s;

  snl_link #(.BIT_PERIOD(P)) i_dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINE_IN(LINE_IN),
    .LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE), .IRQ(IRQ));
  snl_host #(.P(P)) i_host (.CLK(CLK), .LINE_OE(LINE_OE), .line(LINE_IN));

  initial forever #5 CLK = ~CLK;

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task wrap_up;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK) WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK) RD <= 1'b0;
    #1 d = RDATA;
  endtask

  task automatic t_regs;
    rd(ADDR_RX_DATA, v);
    chk("rx_data", v, RESET_BYTE);
    rd(ADDR_IRQ_STAT, v);
    chk("irq_stat", v, 8'h00);
    wr(ADDR_TX_DATA, 8'h5A);
    rd(ADDR_TX_DATA, v);
    chk("tx_data", v, 8'h5A);
    rd(4'hF, v);
    chk("unmapped", v, 8'h00);
    rd(ADDR_STATUS, v);
    chk("status", v & 8'h0B, 8'h08);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, v);
    chk("armed_rb", v, 8'h01);
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_CTRL, v);
    chk("cancel", v, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h07);
  endtask

  // A late start bit must still be awaited, then the whole frame taken.
  task automatic t_rx(input logic [7:0] b, input logic stop);
    int n;
    n = 0;
    wr(ADDR_CTRL, 8'h01);
    repeat (5 * P) @(posedge CLK);
    rd(ADDR_STATUS, v);
    chk("armed", {7'h00, v[ST_RX_BUSY]}, 8'h01);
    i_host.send(b, stop);
    while (IRQ !== 1'b1 && n < 400)
    begin
      @(posedge CLK);
      n++;
    end
    chk("irq", {7'h00, IRQ}, 8'h01);
    rd(ADDR_RX_DATA, v);
    chk("rx_byte", v, b);
    rd(ADDR_STATUS, v);
    chk("stop_ok", {7'h00, v[ST_STOP_OK]}, {7'h00, stop});
    rd(ADDR_IRQ_STAT, v);
    chk("frame_err", {7'h00, v[IRQ_FRAME_ERR]}, {7'h00, ~stop});
    wr(ADDR_IRQ_STAT, 8'h07);
    #1 chk("irq_clr", {7'h00, IRQ}, 8'h00);
  endtask

  task automatic t_tx(input logic [7:0] b);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_TX_DATA, b);
    wr(ADDR_CTRL, 8'h02);
    i_host.get(v, s);
    chk("tx_byte", v, b);
    chk("tx_stop", {7'h00, s}, 8'h01);
    repeat (P) @(posedge CLK);
    rd(ADDR_IRQ_STAT, v);
    chk("tx_done", {7'h00, v[IRQ_TX_DONE]}, 8'h01);
    chk("irq_masked", {7'h00, IRQ}, 8'h00);
    chk("oe_rest", {7'h00, LINE_OE}, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h07);
  endtask

  initial
  begin
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    t_regs;
    t_rx(8'hA5, 1'b1);
    t_rx(8'h3C, 1'b0);
    t_tx(8'h96);
    t_tx(8'h01);
    wrap_up;
  end

  // Whole run needs well under a tenth of this span.
  initial
  begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule

bind snl_link snl_link_props #(.BIT_PERIOD(BIT_PERIOD)) i_props (.CLK(CLK),
  .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .LINE_IN(LINE_IN), .LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE), .IRQ(IRQ));

`default_nettype wire
